// ==== asramc_pkg.sv ====
// constants and state codes for the asynchronous sram host controller
// How it works
// RULE1: memory holds 8192 words of eight bits
// RULE2: memory is static, no clock or refresh
// RULE3: write only while both selects and strobe active
// RULE4: memory floats data pins unless reading
// RULE5: read word valid 70 ns after select/address
// RULE6: read word valid 35 ns after gate low
// RULE7: old word held 10 ns after address change
// RULE8: pins float within 30 ns of deselect
// RULE9: address 60 ns, strobe 40 ns before write end
// RULE10: data set up 30 ns, hold 0 ns
// RULE11: write recovery counted from first select release
// RULE12: strobe low floats memory pins within 30 ns
// RULE13: memory drives again 5 ns after write end
// RULE14: host never drives pins while memory drives
// RULE15: deselect before retention, wait one cycle after
// RULE16: cycles spaced no closer than 70 ns
// RULE17: delays become whole clock counts, rounded up
package asramc_pkg;

   // --------------------------------------------------
   // clock and printed delays, in ns
   // --------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int ADDRESS_TO_DATA_DELAY_NS = 70;
   localparam int GATE_TO_DATA_DELAY_NS = 35;
   localparam int DATA_HOLD_AFTER_ADDRESS_NS = 10;
   localparam int DESELECT_FLOAT_DELAY_NS = 30;
   localparam int ADDRESS_TO_WRITE_END_NS = 60;
   localparam int WRITE_STROBE_WIDTH_NS = 40;
   localparam int DATA_SETUP_TO_WRITE_END_NS = 30;
   localparam int DATA_HOLD_AFTER_WRITE_END_NS = 0;
   localparam int SELECT_WRITE_RECOVERY_NS = 0;
   localparam int STROBE_FLOAT_DELAY_NS = 30;
   localparam int DRIVE_RESUME_AFTER_WRITE_NS = 5;
   localparam int RETENTION_ENTRY_SETUP_NS = 0;
   localparam int READ_CYCLE_PERIOD_NS = 70;

   // least time to whole cycles, never below one
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int max2(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   // --------------------------------------------------
   // cycle counts
   // --------------------------------------------------
   localparam int RD_CYC = max2(cyc_up(ADDRESS_TO_DATA_DELAY_NS),
                                cyc_up(GATE_TO_DATA_DELAY_NS));
   localparam int WR_CYC = max2(max2(cyc_up(ADDRESS_TO_WRITE_END_NS),
                                     cyc_up(WRITE_STROBE_WIDTH_NS)),
                                cyc_up(DATA_SETUP_TO_WRITE_END_NS));
   localparam int FLOAT_CYC = max2(cyc_up(DESELECT_FLOAT_DELAY_NS),
                                   cyc_up(STROBE_FLOAT_DELAY_NS));
   localparam int RC_CYC = cyc_up(READ_CYCLE_PERIOD_NS);
   localparam int WR_REC_CYC = max2(RC_CYC - WR_CYC, 1);

   // timer width and load values (count runs load..0)
   localparam int TMR_W = 4;
   localparam logic [3:0] RD_LOAD = 4'(RD_CYC - 1);
   localparam logic [3:0] WR_LOAD = 4'(WR_CYC - 1);
   localparam logic [3:0] FLOAT_LOAD = 4'(FLOAT_CYC - 1);
   localparam logic [3:0] RC_LOAD = 4'(RC_CYC - 1);
   localparam logic [3:0] WR_REC_LOAD = 4'(WR_REC_CYC - 1);

   // --------------------------------------------------
   // controller states
   // --------------------------------------------------
   typedef enum logic [5:0] {
      ASRAMC_IDLE = 6'h01,
      ASRAMC_RD = 6'h02,
      ASRAMC_WR = 6'h04,
      ASRAMC_TURN = 6'h08,
      ASRAMC_REC = 6'h10,
      ASRAMC_RET = 6'h20
   } asramc_state_t;

endpackage

// ==== asramc_tmr_if.sv ====
// interface between the controller and its interval timer
interface asramc_tmr_if #(parameter int W = 4);
   logic load;
   logic [W-1:0] value;
   logic done;

   modport ctl (output load, output value, input done);
   modport tmr (input load, input value, output done);
endinterface

// ==== asramc_timer.sv ====
// down counter that times the controller's pin phases
module asramc_timer #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // controller side
   asramc_tmr_if.tmr t
);

   typedef struct packed {
      logic [W-1:0] count;
   } asramc_tmr_st_t;

   asramc_tmr_st_t r;
   asramc_tmr_st_t next_r;

   always_comb
   begin
      next_r = r;
      if (t.load)
      begin
         next_r.count = t.value;
      end
      else if (r.count != '0)
      begin
         next_r.count = r.count - 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign t.done = (r.count == '0);

endmodule

// ==== asramc_host.sv ====
// host controller that runs an asynchronous 8k x 8 static ram
module asramc_host #(
   parameter int ADDR_W = 13,
   parameter int DATA_W = 8
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // user request
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_write_i,
   input wire logic [ADDR_W-1:0] req_addr_i,
   input wire logic [DATA_W-1:0] req_wdata_i,
   // user answer
   output logic rsp_valid_o,
   output logic [DATA_W-1:0] rsp_rdata_o,
   // retention control
   input wire logic ret_req_i,
   output logic ret_ack_o,
   // memory pins
   output logic [ADDR_W-1:0] word_address_lines_o,
   output logic select_active_low_n_o,
   output logic select_active_high_o,
   output logic write_strobe_n_o,
   output logic output_gate_n_o,
   input wire logic [DATA_W-1:0] shared_data_pins_i,
   output logic [DATA_W-1:0] shared_data_pins_o,
   output logic shared_data_pins_oe_n_o
);

   // --------------------------------------------------
   // elaboration checks
   // --------------------------------------------------
   generate
      if (ADDR_W < 1 || ADDR_W > 13 || DATA_W != 8)
      begin : g_bad_width
         $error("asramc_host: unsupported address or data width");
      end
      if (asramc_pkg::RC_CYC > 15 || asramc_pkg::RD_CYC > 15)
      begin : g_bad_timer
         $error("asramc_host: timer too narrow for delays");
      end
   endgenerate

   // --------------------------------------------------
   // state
   // --------------------------------------------------
   typedef struct packed {
      asramc_pkg::asramc_state_t st;
      logic [ADDR_W-1:0] addr;
      logic sel_n;
      logic sel_h;
      logic we_n;
      logic gate_n;
      logic doe_n;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic rsp;
      logic ack;
   } asramc_host_st_t;

   asramc_host_st_t r;
   asramc_host_st_t next_r;

   asramc_tmr_if #(.W(asramc_pkg::TMR_W)) tmr ();

   asramc_timer #(.W(asramc_pkg::TMR_W)) u_timer (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .t(tmr.tmr)
   );

   logic idle_ready;

   // retention request outranks new accesses
   assign idle_ready = (r.st == asramc_pkg::ASRAMC_IDLE) && !ret_req_i;
   assign req_ready_o = idle_ready;

   // --------------------------------------------------
   // sequencer
   // --------------------------------------------------
   always_comb
   begin
      next_r = r;
      next_r.rsp = 1'b0;
      tmr.load = 1'b0;
      tmr.value = '0;
      case (r.st)
         asramc_pkg::ASRAMC_IDLE:
         begin
            // RULE15 deselected before retention
            if (ret_req_i)
            begin
               next_r.ack = 1'b1;
               next_r.st = asramc_pkg::ASRAMC_RET;
            end
            else if (req_valid_i)
            begin
               next_r.addr = req_addr_i;
               next_r.sel_n = 1'b0;
               next_r.sel_h = 1'b1;
               if (req_write_i)
               begin
                  // RULE3 strobe low with both selects
                  next_r.we_n = 1'b0;
                  next_r.wdata = req_wdata_i;
                  next_r.doe_n = 1'b0;
                  tmr.load = 1'b1;
                  tmr.value = asramc_pkg::WR_LOAD;
                  next_r.st = asramc_pkg::ASRAMC_WR;
               end
               else
               begin
                  next_r.gate_n = 1'b0;
                  tmr.load = 1'b1;
                  tmr.value = asramc_pkg::RD_LOAD;
                  next_r.st = asramc_pkg::ASRAMC_RD;
               end
            end
         end
         asramc_pkg::ASRAMC_RD:
         begin
            // RULE17 sample after longest access delay
            if (tmr.done)
            begin
               next_r.rdata = shared_data_pins_i;
               next_r.rsp = 1'b1;
               next_r.gate_n = 1'b1;
               next_r.sel_n = 1'b1;
               next_r.sel_h = 1'b0;
               tmr.load = 1'b1;
               tmr.value = asramc_pkg::FLOAT_LOAD;
               next_r.st = asramc_pkg::ASRAMC_TURN;
            end
         end
         asramc_pkg::ASRAMC_WR:
         begin
            // RULE9 address and strobe held full width
            if (tmr.done)
            begin
               // RULE11 selects and strobe release together
               next_r.we_n = 1'b1;
               next_r.sel_n = 1'b1;
               next_r.sel_h = 1'b0;
               // RULE10 data dropped at write end
               next_r.doe_n = 1'b1;
               tmr.load = 1'b1;
               tmr.value = asramc_pkg::WR_REC_LOAD;
               next_r.st = asramc_pkg::ASRAMC_REC;
            end
         end
         asramc_pkg::ASRAMC_TURN:
         begin
            // RULE14 wait for memory pins to float
            if (tmr.done)
            begin
               next_r.st = asramc_pkg::ASRAMC_IDLE;
            end
         end
         asramc_pkg::ASRAMC_REC:
         begin
            // RULE16 pad out the cycle period
            if (tmr.done)
            begin
               next_r.st = asramc_pkg::ASRAMC_IDLE;
            end
         end
         asramc_pkg::ASRAMC_RET:
         begin
            // RULE15 one read cycle before next access
            if (!ret_req_i)
            begin
               next_r.ack = 1'b0;
               tmr.load = 1'b1;
               tmr.value = asramc_pkg::RC_LOAD;
               next_r.st = asramc_pkg::ASRAMC_REC;
            end
         end
         default:
         begin
            next_r.st = asramc_pkg::ASRAMC_IDLE;
            next_r.sel_n = 1'b1;
            next_r.sel_h = 1'b0;
            next_r.we_n = 1'b1;
            next_r.gate_n = 1'b1;
            next_r.doe_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         r <= '0;
         r.st <= asramc_pkg::ASRAMC_IDLE;
         r.sel_n <= 1'b1;
         r.we_n <= 1'b1;
         r.gate_n <= 1'b1;
         r.doe_n <= 1'b1;
      end
      else
      begin
         r <= next_r;
      end
   end

   // --------------------------------------------------
   // outputs
   // --------------------------------------------------
   assign rsp_valid_o = r.rsp;
   assign rsp_rdata_o = r.rdata;
   assign ret_ack_o = r.ack;
   assign word_address_lines_o = r.addr;
   assign select_active_low_n_o = r.sel_n;
   assign select_active_high_o = r.sel_h;
   assign write_strobe_n_o = r.we_n;
   assign output_gate_n_o = r.gate_n;
   assign shared_data_pins_o = r.wdata;
   assign shared_data_pins_oe_n_o = r.doe_n;

   // --------------------------------------------------
   // checks
   // --------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_strobe_low;
      !write_strobe_n_o [*6];
   endsequence

   sequence s_gate_low;
      !output_gate_n_o [*7];
   endsequence

   AST_WRITE_SELECTED: // RULE3
   assert property (!write_strobe_n_o |->
      (!select_active_low_n_o && select_active_high_o))
      else $error("write strobe low without both selects");

   AST_STROBE_WIDTH: // RULE9
   assert property ($fell(write_strobe_n_o) |->
      s_strobe_low ##1 write_strobe_n_o)
      else $error("write strobe width wrong");

   AST_ADDR_STABLE: // RULE9
   assert property (!write_strobe_n_o && $past(!write_strobe_n_o) |->
      $stable(word_address_lines_o))
      else $error("address moved during write");

   AST_DATA_SETUP: // RULE10
   assert property ($rose(write_strobe_n_o) |->
      $past(!shared_data_pins_oe_n_o, 3) && $past(!shared_data_pins_oe_n_o))
      else $error("write data not set up before write end");

   AST_NO_CONTENTION: // RULE14
   assert property (!shared_data_pins_oe_n_o |-> output_gate_n_o)
      else $error("host drives pins while gate is open");

   AST_FLOAT_WAIT: // RULE14
   assert property ($rose(output_gate_n_o) |->
      shared_data_pins_oe_n_o [*3])
      else $error("host drove pins before memory floated");

   AST_READ_SAMPLE: // RULE17
   assert property ($fell(output_gate_n_o) |->
      s_gate_low ##1 (output_gate_n_o && rsp_valid_o))
      else $error("read sampled at wrong time");

   AST_RET_DESELECT: // RULE15
   assert property (ret_ack_o |-> select_active_low_n_o
      && !select_active_high_o)
      else $error("retention while selected");

   AST_RET_RECOVER: // RULE15
   assert property ($fell(ret_ack_o) |-> !req_ready_o [*7])
      else $error("access too soon after retention");

   AST_RELEASE_TOGETHER: // RULE11
   assert property ($rose(write_strobe_n_o) |->
      (select_active_low_n_o && !select_active_high_o && !req_ready_o)
      ##1 (r.st == asramc_pkg::ASRAMC_IDLE))
      else $error("selects not released with write end");

endmodule

// ==== asramc_sram_model.sv ====
// behavioural model of the 8k x 8 static ram seen by the host
module asramc_sram_model (
   // memory pins
   input wire logic [12:0] word_address_lines_i,
   input wire logic select_active_low_n_i,
   input wire logic select_active_high_i,
   input wire logic write_strobe_n_i,
   input wire logic output_gate_n_i,
   input wire logic [7:0] shared_data_pins_i,
   input wire logic host_drive_n_i,
   // model outputs
   output logic [7:0] shared_data_pins_o,
   output logic drive_o,
   output logic [7:0] fault_count_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [8192];
   realtime now, t_acc, t_adr, t_gate, t_wr, t_dat, t_on, t_off, t_cyc;
   logic sel, rd_on, wr_on, p_sel, p_rd, p_wr, p_gate;
   logic [12:0] p_adr;
   logic [7:0] p_dat;
   assign sel = !select_active_low_n_i && select_active_high_i;
   assign rd_on = sel && !output_gate_n_i && write_strobe_n_i;
   // write needs both selects and strobe
   assign wr_on = sel && !write_strobe_n_i;
   initial
   begin
      {p_sel, p_rd, p_wr, p_gate, drive_o} = 5'h02;
      {p_adr, p_dat, shared_data_pins_o, fault_count_o} = '0;
      t_acc = 0.0;
      t_adr = 0.0;
      t_gate = 0.0;
      t_wr = 0.0;
      t_dat = 0.0;
      t_on = 0.0;
      t_off = 0.0;
      t_cyc = -1000.0;
      #0.5;
      forever
      begin
         now = $realtime;
         if (wr_on)
            mem[word_address_lines_i] = shared_data_pins_i;
         if (!wr_on && p_wr && (now - t_wr < 40.0 || now - t_adr < 60.0
             || now - t_dat < 30.0))
            fault_count_o++;
         if (sel && !p_sel)
         begin
            if (now - t_cyc < 70.0)
               fault_count_o++;
            t_cyc = now;
         end
         if (word_address_lines_i !== p_adr)
            t_adr = now;
         if (word_address_lines_i !== p_adr || sel !== p_sel)
            t_acc = now;
         if (output_gate_n_i !== p_gate)
            t_gate = now;
         if (shared_data_pins_i !== p_dat)
            t_dat = now;
         if (wr_on && !p_wr)
            t_wr = now;
         if (rd_on && !p_rd)
            t_on = now;
         if (!rd_on && p_rd)
            t_off = now;
         if (rd_on && now - t_on >= 5.0)
            drive_o = 1'b1;
         else if (!rd_on && now - t_off >= 30.0)
            drive_o = 1'b0;
         if (rd_on && now - t_acc >= 69.0 && now - t_gate >= 34.0)
            shared_data_pins_o = mem[word_address_lines_i];
         else if (!(rd_on && now - t_acc < 10.0))
            shared_data_pins_o = ~shared_data_pins_o;
         if (drive_o && !host_drive_n_i)
            fault_count_o++;
         {p_sel, p_rd, p_wr, p_gate} = {sel, rd_on, wr_on, output_gate_n_i};
         p_adr = word_address_lines_i;
         p_dat = shared_data_pins_i;
         #1;
      end
   end
endmodule

// ==== test_async_sram_8k_by_8_port.sv ====
// self-checking bench for the asynchronous sram host controller
module test_async_sram_8k_by_8_port;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_i, rst_i, req_valid_i, req_write_i, ret_req_i;
   logic req_ready_o, rsp_valid_o, ret_ack_o, sel_n, sel_h, we_n, gate_n;
   logic oe_n, host_oe_n, drive;
   logic [12:0] req_addr_i, addr;
   logic [7:0] req_wdata_i, rdata, pins_o, pins, mem_d, host_d, faults;
   int miscompares = 0;
   int cmp_count = 0;
   logic [12:0] adr_tab [3] = '{13'h0000, 13'h1fff, 13'h0aaa};
   logic [7:0] dat_tab [3] = '{8'ha5, 8'h5a, 8'h3c};
   // host data reaches the wire a little late, giving hold after release
   assign #1 host_d = pins_o;
   assign #1 host_oe_n = oe_n;
   assign pins = host_oe_n ? mem_d : host_d;
   asramc_host u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
      .req_write_i(req_write_i), .req_addr_i(req_addr_i),
      .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o),
      .rsp_rdata_o(rdata), .ret_req_i(ret_req_i), .ret_ack_o(ret_ack_o),
      .word_address_lines_o(addr), .select_active_low_n_o(sel_n),
      .select_active_high_o(sel_h), .write_strobe_n_o(we_n),
      .output_gate_n_o(gate_n), .shared_data_pins_i(pins),
      .shared_data_pins_o(pins_o), .shared_data_pins_oe_n_o(oe_n));
   asramc_sram_model u_mem (.word_address_lines_i(addr),
      .select_active_low_n_i(sel_n), .select_active_high_i(sel_h),
      .write_strobe_n_i(we_n), .output_gate_n_i(gate_n),
      .shared_data_pins_i(pins), .host_drive_n_i(oe_n),
      .shared_data_pins_o(mem_d), .drive_o(drive), .fault_count_o(faults));
   initial
   begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic do_req(input logic wr, input logic [12:0] a,
                         input logic [7:0] d);
      int n;
      @(posedge ref_clk_i);
      #1;
      {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, wr, a, d};
      // ready is looked at between edges, never in the take edge itself
      n = 0;
      while (req_ready_o !== 1'b1 && n < 50)
      begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      chk(req_ready_o, 1'b1);
      @(posedge ref_clk_i);
      #1;
      req_valid_i = 1'b0;
      chk({sel_n, sel_h, we_n, oe_n}, wr ? 4'h4 : 4'h7);
      chk(addr, a);
      if (wr)
         chk(pins_o, d);
      else
         chk(gate_n, 1'b0);
   endtask
   task automatic rd_exp(input logic [12:0] a, input logic [7:0] d);
      int n;
      do_req(1'b0, a, 8'h00);
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      while (rsp_valid_o !== 1'b1 && n < 20);
      chk(16'(n), 16'(asramc_pkg::RD_CYC));
      chk(rdata, d);
   endtask
   task automatic test_reset();
      chk({sel_n, sel_h, we_n, gate_n, oe_n, ret_ack_o, rsp_valid_o,
           req_ready_o}, 8'hb9);
      $display("test reset done");
   endtask
   task automatic test_rw();
      for (int i = 0; i < 3; i++)
         do_req(1'b1, adr_tab[i], dat_tab[i]);
      for (int i = 0; i < 3; i++)
         rd_exp(adr_tab[i], dat_tab[i]);
      $display("test write read done");
   endtask
   task automatic test_b2b();
      rd_exp(adr_tab[0], dat_tab[0]);
      do_req(1'b1, adr_tab[0], 8'hc3);
      rd_exp(adr_tab[0], 8'hc3);
      rd_exp(adr_tab[2], dat_tab[2]);
      $display("test back to back done");
   endtask
   task automatic test_ret();
      int n;
      @(posedge ref_clk_i);
      #1;
      ret_req_i = 1'b1;
      {req_valid_i, req_write_i, req_addr_i, req_wdata_i} =
         {1'b1, 1'b1, adr_tab[1], 8'h00};
      repeat (4) @(posedge ref_clk_i);
      #1;
      chk({ret_ack_o, sel_n, sel_h, we_n, req_ready_o}, 5'h1a);
      ret_req_i = 1'b0;
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      while (req_ready_o !== 1'b1 && n < 20);
      req_valid_i = 1'b0;
      chk({ret_ack_o, 8'(n)}, 9'h008);
      rd_exp(adr_tab[1], dat_tab[1]);
      $display("test retention done");
   endtask
   initial
   begin
      {rst_i, req_valid_i, req_write_i, ret_req_i} = 4'h8;
      {req_addr_i, req_wdata_i} = '0;
      repeat (12) @(posedge ref_clk_i);
      #1;
      rst_i = 1'b0;
      test_reset();
      test_rw();
      test_b2b();
      test_ret();
      chk(faults, 8'h00);
      print_verdict();
   end
   initial
   begin
      #60000;
      miscompares++;
      print_verdict();
   end
endmodule
